/* core/cpdr_cadence.sv */
/*
 * Frame counter that strobes the frame check and link integrity updates.
 * Assumes one frame-start pulse per frame.
 */
`timescale 1ns/100ps
`default_nettype none
module cpdr_cadence
	import cpdr_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_clk_en,
	input  wire logic i_frame,
	input  wire logic i_fast,
	output logic      o_fc_strobe,
	output logic      o_li_strobe
);
	logic [6:0] cnt_r;
	logic [6:0] fc_m;
	logic [6:0] li_m;

	assign fc_m = i_fast ? FC_FAST : FC_SLOW;
	assign li_m = i_fast ? LI_FAST : LI_SLOW;

	// Count frames and strobe on period boundaries
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r       <= 7'h00;
			o_fc_strobe <= 1'b0;
			o_li_strobe <= 1'b0;
		end else if (i_clk_en) begin
			o_fc_strobe <= i_frame && ((cnt_r & fc_m) == fc_m);
			o_li_strobe <= i_frame && ((cnt_r & li_m) == li_m);
			if (i_frame) begin
				cnt_r <= cnt_r + 7'h01;
			end
		end
	end

	a_li_fast_period: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && i_fast && i_frame && cnt_r[3:0] == 4'hf |=> o_li_strobe)
		else $error("integrity strobe missed in fast mode");
	a_fc_slow_gap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && !i_fast && i_frame && cnt_r[3:0] != 4'hf |=> !o_fc_strobe)
		else $error("frame check strobe too early in slow mode");
endmodule : cpdr_cadence
`default_nettype wire

/* core/cpdr_key_mem.sv */
/*
 * Key-list storage: one write port, one registered read port.
 * Assumes writes and reads in the single system clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module cpdr_key_mem
	import cpdr_pkg::*;
#(
	parameter int DW = 8,
	parameter int AW = KEY_AW
) (
	input  wire logic          i_clk,
	input  wire logic          i_clk_en,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [DW-1:0] i_wdata,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [DW-1:0] o_rdata
);
	logic [DW-1:0] mem [2**AW];

	// Store and fetch
	always_ff @(posedge i_clk) begin
		if (i_clk_en) begin
			if (i_we) begin
				mem[i_waddr] <= i_wdata;
			end
			o_rdata <= mem[i_raddr];
		end
	end
endmodule : cpdr_key_mem
`default_nettype wire

/* core/cpdr_pkg.sv */
/*
 * Constants shared by the content-protection debug/status register block:
 * register indices, field positions, reset values and timing figures.
 * Assumes a single 250 MHz clock and a 32-bit Avalon-MM register bus.
 */
// Functional notes
// - Idle bus over one second counts free
// - Timeout-disable bit turns bus timeout off
// - Mirror bits read-only, copied from transmitter
// - Ones-complement checksum per channel each line
// - Fast verify: check 2, integrity 16 frames
// - Slow verify: check 16, integrity 128 frames
// - Timer speedup bit accelerates authentication timers
// - Bit 0 picks fast or standard timing
// - Bypass bit passes encrypted pixels through
// - Policy bit keeps or re-enables downstream protection
// - Checksum mismatch sets status bit 1
// - Status write with byte lane 0 enabled clears checksum error unless a mismatch lands that cycle
// - Successful authentication sets status bit 0
// - Lost or restarted authentication clears flag
// - Write port stores byte at pointer
// - Pointer zeroed first, then auto-increments
package cpdr_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_DBG_MIRROR = 8'hc0;
	localparam logic [7:0] IDX_DBG_CTRL   = 8'hc1;
	localparam logic [7:0] IDX_STATUS     = 8'hc4;
	localparam logic [7:0] IDX_KEY_WRITE  = 8'hc9;
	localparam logic [7:0] IDX_PTR_LO     = 8'hca;
	localparam logic [7:0] IDX_PTR_HI     = 8'hcb;
	// Field positions
	localparam int BIT_TO_DIS  = 6;
	localparam int BIT_CHK_EN  = 3;
	localparam int BIT_FAST_LINK_VERIFY = 2;
	localparam int BIT_TMR_ACC = 1;
	localparam int BIT_I2C_FST = 0;
	localparam int BIT_BYPASS  = 1;
	localparam int BIT_POLICY  = 0;
	localparam int BIT_CHK_ERR = 1;
	localparam int BIT_AUTH_COMPLETE  = 0;
	// Writable or defined bits per register
	localparam logic [7:0] MIRROR_MASK = 8'h4f;
	localparam logic [7:0] CTRL_MASK   = 8'h03;
	localparam logic [7:0] RST_VAL     = 8'h00;
	// Verification cadence masks, period in frames minus one
	localparam logic [6:0] FC_FAST = 7'h01;
	localparam logic [6:0] LI_FAST = 7'h0f;
	localparam logic [6:0] FC_SLOW = 7'h0f;
	localparam logic [6:0] LI_SLOW = 7'h7f;
	// Bus idle timeout
	localparam int TIMEOUT_MS  = 1000;
	localparam int CLK_MHZ     = 250;
	localparam int IDLE_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int KEY_AW      = 9;
endpackage : cpdr_pkg

/* core/cpdr_regs.sv */
/*
 * Content-protection debug and status register bank with key-list write port.
 * Assumes an Avalon-MM master with waitrequest, one 250 MHz clock, and
 * pulses from the authentication engine and video path in the same domain.
 */
`timescale 1ns/100ps
`default_nettype none
module cpdr_regs
	import cpdr_pkg::*;
#(
	parameter int IDLE_LIMIT = IDLE_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	input  wire logic [9:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [7:0]  i_remote_dbg,
	input  wire logic        i_i2c_activity,
	input  wire logic        i_frame_start,
	input  wire logic        i_pix_valid,
	input  wire logic [23:0] i_pix_clear,
	input  wire logic [23:0] i_pix_cipher,
	input  wire logic        i_line_end,
	input  wire logic [23:0] i_line_chksum,
	input  wire logic        i_auth_done,
	input  wire logic        i_auth_lost,
	input  wire logic        i_auth_restart,
	input  wire logic        i_auth_start,
	input  wire logic        i_tx_prot_on,
	input  wire logic [8:0]  i_key_raddr,
	output logic      [7:0]  o_key_rdata,
	output logic      [23:0] o_pix_data,
	output logic             o_i2c_fast,
	output logic             o_i2c_timeout_en,
	output logic             o_i2c_bus_free,
	output logic             o_auth_timer_accel,
	output logic             o_fc_strobe,
	output logic             o_li_strobe,
	output logic             o_reenable_prot,
	output logic             o_auth_complete
);
	logic [7:0]  mirror_r;
	logic [7:0]  ctrl_r;
	logic        chk_err_r;
	logic [7:0]  key_last_r;
	logic [8:0]  ptr_r;
	logic [31:0] idle_cnt_r;
	logic [2:0]  ch_bad;
	logic        req;
	logic        wr_go;
	logic [7:0]  idx;
	logic [7:0]  rd_nxt;
	logic        key_we;

	assign req    = i_avs_read || i_avs_write;
	assign idx    = i_avs_address[9:2];
	assign wr_go  = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	assign key_we = wr_go && idx == IDX_KEY_WRITE;

	// Waitrequest drops for one cycle, the cycle after a request appears
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_avs_waitrequest <= 1'b1;
		end else if (i_clk_en) begin
			o_avs_waitrequest <= !(req && o_avs_waitrequest);
		end
	end

	// Read mux, reserved bits and unmapped addresses read zero
	always_comb begin
		rd_nxt = RST_VAL;
		unique case (idx)
			IDX_DBG_MIRROR: rd_nxt = mirror_r;
			IDX_DBG_CTRL:   rd_nxt = ctrl_r;
			IDX_STATUS:     rd_nxt = {6'h00, chk_err_r, o_auth_complete};
			IDX_KEY_WRITE:  rd_nxt = key_last_r;
			IDX_PTR_LO:     rd_nxt = ptr_r[7:0];
			IDX_PTR_HI:     rd_nxt = {7'h00, ptr_r[8]};
			default:        rd_nxt = RST_VAL;
		endcase
	end

	// Read data registered while waitrequest is still high
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_clk_en && i_avs_read && o_avs_waitrequest) begin
			o_avs_readdata <= {24'h00_0000, rd_nxt};
		end
	end

	// Mirror of the remote transmitter's debug register, never written here
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mirror_r <= RST_VAL;
		end else if (i_clk_en) begin
			mirror_r <= i_remote_dbg & MIRROR_MASK;
		end
	end

	// Local control register, reserved bits dropped
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_r <= RST_VAL;
		end else if (i_clk_en && wr_go && idx == IDX_DBG_CTRL) begin
			ctrl_r <= i_avs_writedata[7:0] & CTRL_MASK;
		end
	end

	// Key-list pointer: set by software, stepped by each data write
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ptr_r      <= 9'h000;
			key_last_r <= RST_VAL;
		end else if (i_clk_en && wr_go) begin
			if (idx == IDX_PTR_LO) begin
				ptr_r[7:0] <= i_avs_writedata[7:0];
			end else if (idx == IDX_PTR_HI) begin
				ptr_r[8] <= i_avs_writedata[0];
			end else if (key_we) begin
				ptr_r      <= ptr_r + 9'h001;
				key_last_r <= i_avs_writedata[7:0];
			end
		end
	end

	cpdr_key_mem #(
		.DW (8),
		.AW (KEY_AW)
	) u_key_mem (
		.i_clk    (i_clk),
		.i_clk_en (i_clk_en),
		.i_we     (key_we),
		.i_waddr  (ptr_r),
		.i_wdata  (i_avs_writedata[7:0]),
		.i_raddr  (i_key_raddr),
		.o_rdata  (o_key_rdata)
	);

	// Per-channel ones-complement line sums
	generate
		for (genvar c = 0; c < 3; c++) begin : g_chk
			logic [7:0] sum_r;
			logic [8:0] s;
			assign s = {1'b0, sum_r} + {1'b0, i_pix_clear[8*c +: 8]};
			assign ch_bad[c] = (~sum_r) != i_line_chksum[8*c +: 8];
			always_ff @(posedge i_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					sum_r <= 8'h00;
				end else if (i_clk_en) begin
					if (i_line_end) begin
						sum_r <= 8'h00;
					end else if (i_pix_valid) begin
						sum_r <= s[7:0] + {7'h00, s[8]};
					end
				end
			end
		end
	endgenerate

	// Status flags; a hardware set wins over a clear in the same cycle
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			chk_err_r       <= 1'b0;
			o_auth_complete <= 1'b0;
		end else if (i_clk_en) begin
			if (i_line_end && mirror_r[BIT_CHK_EN] && |ch_bad) begin
				chk_err_r <= 1'b1;
			end else if (wr_go && idx == IDX_STATUS) begin
				chk_err_r <= 1'b0;
			end
			if (i_auth_done) begin
				o_auth_complete <= 1'b1;
			end else if (i_auth_lost || i_auth_restart) begin
				o_auth_complete <= 1'b0;
			end
		end
	end

	// Bus idle timeout for the protection I2C master
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			idle_cnt_r     <= 32'h0000_0000;
			o_i2c_bus_free <= 1'b0;
		end else if (i_clk_en) begin
			if (i_i2c_activity || mirror_r[BIT_TO_DIS]) begin
				idle_cnt_r     <= 32'h0000_0000;
				o_i2c_bus_free <= 1'b0;
			end else if (idle_cnt_r < 32'(IDLE_LIMIT)) begin
				idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
			end else begin
				o_i2c_bus_free <= 1'b1;
			end
		end
	end

	// Mode outputs and pixel path
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_i2c_fast         <= 1'b0;
			o_i2c_timeout_en   <= 1'b0;
			o_auth_timer_accel <= 1'b0;
			o_pix_data         <= 24'h00_0000;
			o_reenable_prot    <= 1'b0;
		end else if (i_clk_en) begin
			o_i2c_fast         <= mirror_r[BIT_I2C_FST];
			o_i2c_timeout_en   <= !mirror_r[BIT_TO_DIS];
			o_auth_timer_accel <= mirror_r[BIT_TMR_ACC];
			o_pix_data <= ctrl_r[BIT_BYPASS] ? i_pix_cipher : i_pix_clear;
			o_reenable_prot <= i_auth_start &&
				!(ctrl_r[BIT_POLICY] && i_tx_prot_on);
		end
	end

	cpdr_cadence u_cadence (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_clk_en    (i_clk_en),
		.i_frame     (i_frame_start),
		.i_fast      (mirror_r[BIT_FAST_LINK_VERIFY]),
		.o_fc_strobe (o_fc_strobe),
		.o_li_strobe (o_li_strobe)
	);

	// Bus handshake: one answer cycle per request, frozen with the enable
	a_wait_one_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && !o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_wait_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && req && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("request not answered in the next cycle");
	a_rd_upper_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	// Register contents and reserved bits
	a_mirror_ro: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en ##1 i_clk_en |-> mirror_r == ($past(i_remote_dbg) & MIRROR_MASK))
		else $error("mirror register diverged from remote");
	a_mirror_rsvd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(mirror_r & ~MIRROR_MASK) == 8'h00)
		else $error("mirror reserved bit set");
	a_ctrl_rsvd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(ctrl_r & ~CTRL_MASK) == 8'h00)
		else $error("control reserved bit set");
	a_ctrl_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && wr_go && idx == IDX_DBG_CTRL
		|=> ctrl_r == ($past(i_avs_writedata[7:0]) & CTRL_MASK))
		else $error("control write not taken");
	a_ptr_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && key_we |=> ptr_r == $past(ptr_r) + 9'h001)
		else $error("key pointer did not advance");
	a_key_last: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && key_we |=> key_last_r == $past(i_avs_writedata[7:0]))
		else $error("key byte not captured");

	// Status flags
	a_status_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && wr_go && idx == IDX_STATUS && !i_line_end |=> !chk_err_r)
		else $error("status write did not clear checksum error");
	a_chk_err_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && i_line_end && mirror_r[BIT_CHK_EN] && |ch_bad |=> chk_err_r)
		else $error("checksum mismatch not flagged");
	a_chk_err_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!mirror_r[BIT_CHK_EN] && !chk_err_r |=> !chk_err_r)
		else $error("checksum error set while disabled");
	a_auth_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && i_auth_done |=> o_auth_complete)
		else $error("auth complete not set");
	a_auth_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && !i_auth_done && (i_auth_lost || i_auth_restart)
		|=> !o_auth_complete)
		else $error("auth complete not cleared");

	// Mode outputs, bus timeout and pixel path
	a_fast_timing: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && $stable(mirror_r) |=> o_i2c_fast == $past(mirror_r[BIT_I2C_FST]))
		else $error("fast timing select wrong");
	a_timeout_en: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en |=> o_i2c_timeout_en == !$past(mirror_r[BIT_TO_DIS]))
		else $error("timeout enable wrong");
	a_timer_accel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en |=> o_auth_timer_accel == $past(mirror_r[BIT_TMR_ACC]))
		else $error("timer speedup select wrong");
	a_free_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && (mirror_r[BIT_TO_DIS] || i_i2c_activity) |=> !o_i2c_bus_free)
		else $error("bus free while active or disabled");
	a_free_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && !i_i2c_activity && !mirror_r[BIT_TO_DIS] &&
		idle_cnt_r >= 32'(IDLE_LIMIT) |=> o_i2c_bus_free)
		else $error("bus not free after idle limit");
	a_bypass_pix: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && ctrl_r[BIT_BYPASS] |=> o_pix_data == $past(i_pix_cipher))
		else $error("bypass did not pass encrypted data");
	a_clear_pix: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && !ctrl_r[BIT_BYPASS] |=> o_pix_data == $past(i_pix_clear))
		else $error("decrypted data not passed");
	a_policy_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && i_auth_start && ctrl_r[BIT_POLICY] && i_tx_prot_on |=> !o_reenable_prot)
		else $error("protection re-enabled against policy");
	a_policy_redo: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && i_auth_start && !ctrl_r[BIT_POLICY] |=> o_reenable_prot)
		else $error("protection not re-enabled at start");
endmodule : cpdr_regs
`default_nettype wire

/* verification/cpdr_regs_tb.sv */
/*
 * Self-checking bench for the protection debug/status register bank.
 * Assumes cpdr_pkg and the far-end model cpdr_remote_tx compile first.
 */
`timescale 1ns/100ps
`default_nettype none
module cpdr_regs_tb import cpdr_pkg::*; ;
	localparam int LIM = 20;
	logic i_clk, i_sys_rst, i_clk_en, i_avs_read, i_avs_write;
	logic i_i2c_activity, i_tx_prot_on, bypass = 1'b0, pix_chk = 1'b0;
	logic i_auth_done, i_auth_lost, i_auth_restart, i_auth_start;
	logic [9:0]  i_avs_address;
	logic [31:0] i_avs_writedata;
	logic [3:0]  i_avs_byteenable;
	logic [8:0]  i_key_raddr;
	logic [23:0] exp_pix          = '0;
	logic [7:0]  dbg, kb [4];
	logic [31:0] o_avs_readdata, expq [$];
	logic [7:0]  o_key_rdata;
	logic [23:0] o_pix_data;
	logic o_avs_waitrequest, o_i2c_fast, o_i2c_timeout_en, o_i2c_bus_free, o_auth_timer_accel;
	logic o_fc_strobe, o_li_strobe, o_reenable_prot, o_auth_complete;
	wire logic [7:0]  i_remote_dbg;
	wire logic [23:0] i_pix_clear, i_pix_cipher, i_line_chksum;
	wire logic        i_frame_start, i_pix_valid, i_line_end;
	integer seed = 32'h12cd8f2a;
	int n_errors = 0, n_checks = 0, n_fc = 0, n_li = 0, n_re = 0, cyc = 0, f0, l0;
	// Clock, 4 ns period
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	cpdr_regs #(.IDLE_LIMIT(LIM)) dut_u (.i_clk, .i_sys_rst, .i_clk_en,
		.i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
		.o_avs_readdata, .o_avs_waitrequest, .i_remote_dbg, .i_i2c_activity,
		.i_frame_start, .i_pix_valid, .i_pix_clear, .i_pix_cipher, .i_line_end,
		.i_line_chksum, .i_auth_done, .i_auth_lost, .i_auth_restart, .i_auth_start,
		.i_tx_prot_on, .i_key_raddr, .o_key_rdata, .o_pix_data, .o_i2c_fast,
		.o_i2c_timeout_en, .o_i2c_bus_free, .o_auth_timer_accel, .o_fc_strobe,
		.o_li_strobe, .o_reenable_prot, .o_auth_complete);
	cpdr_remote_tx rtx_u (.i_clk, .o_dbg(i_remote_dbg), .o_frame(i_frame_start),
		.o_valid(i_pix_valid), .o_clear(i_pix_clear), .o_cipher(i_pix_cipher),
		.o_line_end(i_line_end), .o_chksum(i_line_chksum));
	// Compare and count
	task check(input string what, input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	// Verdict and end of run
	task tally_and_finish;
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	// One Avalon-MM transfer, held until waitrequest is sampled low
	task bus(input logic we, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
		@(posedge i_clk);
		i_avs_read       <= ~we;
		i_avs_write      <= we;
		i_avs_address    <= {idx, 2'b00};
		i_avs_writedata  <= {$random(seed)} & 32'hffffff00 | {24'h0, wd};
		i_avs_byteenable <= be;
		do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
		i_avs_read  <= 1'b0;
		i_avs_write <= 1'b0;
	endtask : bus
	// Reads note their expected value for the monitor
	task rd(input logic [7:0] idx, input logic [7:0] want);
		expq.push_back({24'h0, want});
		bus(1'b0, idx, 8'h00, 4'hf);
	endtask : rd
	task wr(input logic [7:0] idx, input logic [7:0] wd);
		bus(1'b1, idx, wd, 4'h1);
	endtask : wr
	// One-cycle pulse on {done, lost, restart, start}
	task pulse(input logic [3:0] m);
		@(posedge i_clk);
		{i_auth_done, i_auth_lost, i_auth_restart, i_auth_start} <= m;
		@(posedge i_clk);
		{i_auth_done, i_auth_lost, i_auth_restart, i_auth_start} <= 4'h0;
		repeat (3) @(posedge i_clk);
	endtask : pulse
	// Monitor: oldest note against each answered read
	always @(posedge i_clk) begin
		if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
			check("readdata", o_avs_readdata, expq.pop_front());
		end
	end
	// Pixel path, strobe counts and timeout
	always @(posedge i_clk) begin
		if (pix_chk) check("pix_data", o_pix_data, exp_pix);
		exp_pix <= bypass ? i_pix_cipher : i_pix_clear;
		if (o_fc_strobe === 1'b1) n_fc++;
		if (o_li_strobe === 1'b1) n_li++;
		if (o_reenable_prot === 1'b1) n_re++;
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// Main sequence
	initial begin
		{i_sys_rst, i_clk_en} <= 2'b11;
		{i_avs_read, i_avs_write, i_i2c_activity, i_tx_prot_on} <= 4'h0;
		{i_auth_done, i_auth_lost, i_auth_restart, i_auth_start} <= 4'h0;
		{i_avs_address, i_avs_writedata, i_avs_byteenable, i_key_raddr} <= '0;
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(IDX_DBG_MIRROR, RST_VAL);
		rd(IDX_DBG_CTRL, RST_VAL);
		rd(IDX_STATUS, RST_VAL);
		rd(8'h10, 8'h00);
		repeat (6) begin
			dbg = 8'($random(seed));
			rtx_u.set_dbg(dbg);
			repeat (4) @(posedge i_clk);
			check("i2c_fast", o_i2c_fast, dbg[BIT_I2C_FST]);
			check("timeout_en", o_i2c_timeout_en, !dbg[BIT_TO_DIS]);
			check("timer_accel", o_auth_timer_accel, dbg[BIT_TMR_ACC]);
			wr(IDX_DBG_MIRROR, ~dbg);
			rd(IDX_DBG_MIRROR, dbg & MIRROR_MASK);
		end
		rtx_u.set_dbg(8'h00);
		i_i2c_activity <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_i2c_activity <= 1'b0;
		repeat (LIM + 1) @(posedge i_clk);
		check("bus_free", o_i2c_bus_free, 1'b0);
		@(posedge i_clk);
		check("bus_free", o_i2c_bus_free, 1'b1);
		i_i2c_activity <= 1'b1;
		repeat (3) @(posedge i_clk);
		check("bus_free", o_i2c_bus_free, 1'b0);
		i_i2c_activity <= 1'b0;
		rtx_u.set_dbg(8'h40);
		repeat (LIM + 8) @(posedge i_clk);
		check("bus_free", o_i2c_bus_free, 1'b0);
		wr(IDX_DBG_CTRL, 8'hff);
		rd(IDX_DBG_CTRL, CTRL_MASK);
		bus(1'b1, IDX_DBG_CTRL, 8'h00, 4'he);
		rd(IDX_DBG_CTRL, CTRL_MASK);
		bypass  <= 1'b1;
		pix_chk <= 1'b1;
		rtx_u.send_line(1'b0);
		wr(IDX_DBG_CTRL, 8'h01);
		bypass <= 1'b0;
		rtx_u.send_line(1'b0);
		pix_chk      <= 1'b0;
		i_tx_prot_on <= 1'b1;
		pulse(4'h1);
		check("reenable", n_re, 0);
		i_tx_prot_on <= 1'b0;
		pulse(4'h1);
		check("reenable", n_re, 1);
		wr(IDX_DBG_CTRL, 8'h00);
		i_tx_prot_on <= 1'b1;
		pulse(4'h1);
		check("reenable", n_re, 2);
		pulse(4'h8);
		check("auth", o_auth_complete, 1'b1);
		rd(IDX_STATUS, 8'h01);
		pulse(4'h4);
		check("auth", o_auth_complete, 1'b0);
		pulse(4'h8);
		pulse(4'h2);
		rd(IDX_STATUS, 8'h00);
		rtx_u.set_dbg(8'h08);
		rtx_u.send_line(1'b0);
		wr(IDX_STATUS, 8'h00);
		rtx_u.send_line(1'b0);
		rd(IDX_STATUS, 8'h00);
		rtx_u.send_line(1'b1);
		rd(IDX_STATUS, 8'h02);
		wr(IDX_STATUS, 8'($random(seed)));
		rd(IDX_STATUS, 8'h00);
		rtx_u.set_dbg(8'h00);
		repeat (3) @(posedge i_clk);
		rtx_u.send_line(1'b1);
		rd(IDX_STATUS, 8'h00);
		for (int f = 0; f < 2; f++) begin
			rtx_u.set_dbg(f ? 8'h00 : 8'h04);
			repeat (3) @(posedge i_clk);
			f0 = n_fc;
			l0 = n_li;
			rtx_u.frames(f ? 128 : 16);
			repeat (3) @(posedge i_clk);
			check("fc_count", n_fc - f0, 8);
			check("li_count", n_li - l0, 1);
		end
		wr(IDX_PTR_LO, 8'h00);
		wr(IDX_PTR_HI, 8'h00);
		for (int k = 0; k < 4; k++) begin
			kb[k] = 8'($random(seed));
			if (k == 3) wr(IDX_PTR_LO, 8'hff);
			if (k == 3) wr(IDX_PTR_HI, 8'h01);
			wr(IDX_KEY_WRITE, kb[k]);
		end
		rd(IDX_KEY_WRITE, kb[3]);
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			i_key_raddr <= (k == 3) ? 9'h1ff : 9'(k);
			repeat (2) @(posedge i_clk);
			check("key_rdata", o_key_rdata, kb[k]);
		end
		// Enable low freezes the mode outputs; they follow once it returns
		i_clk_en <= 1'b0;
		rtx_u.set_dbg(8'h01);
		repeat (4) @(posedge i_clk);
		check("frozen_fast", o_i2c_fast, 1'b0);
		i_clk_en <= 1'b1;
		repeat (3) @(posedge i_clk);
		check("i2c_fast", o_i2c_fast, 1'b1);
		tally_and_finish();
	end
endmodule : cpdr_regs_tb
`default_nettype wire

/* verification/cpdr_remote_tx.sv */
/*
 * Far-end model: remote transmitter debug byte, frame pulses, video lines.
 * Assumes its tasks are called from the bench in the system clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module cpdr_remote_tx (
	input  wire logic        i_clk,
	output logic      [7:0]  o_dbg,
	output logic             o_frame,
	output logic             o_valid,
	output logic      [23:0] o_clear,
	output logic      [23:0] o_cipher,
	output logic             o_line_end,
	output logic      [23:0] o_chksum
);
	integer seed = 32'h12cd8f2a;
	// Quiet link at time zero
	initial begin
		{o_dbg, o_frame, o_valid, o_clear, o_cipher, o_line_end, o_chksum} = '0;
	end
	// Debug byte programmed on the far end
	task set_dbg(input logic [7:0] v);
		@(posedge i_clk);
		o_dbg <= v;
	endtask : set_dbg
	// Frame pulses with a gap cycle between them
	task frames(input int n);
		repeat (n) begin
			@(posedge i_clk);
			o_frame <= 1'b1;
			@(posedge i_clk);
			o_frame <= 1'b0;
		end
	endtask : frames
	// Four pixels, then the inverted per-channel sum; bad flips one bit
	task send_line(input logic bad);
		logic [2:0][8:0] s;
		logic [23:0]     p;
		s = '0;
		repeat (4) begin
			p = 24'($random(seed));
			for (int c = 0; c < 3; c++) begin
				s[c] = s[c][7:0] + p[c*8 +: 8];
				s[c] = s[c][7:0] + s[c][8]; // End-around carry
			end
			@(posedge i_clk);
			o_valid  <= 1'b1;
			o_clear  <= p;
			o_cipher <= p ^ 24'h5a3c96;
		end
		@(posedge i_clk);
		o_valid    <= 1'b0;
		o_clear    <= ~p; // Released pixel lines change
		o_line_end <= 1'b1;
		o_chksum   <= ~{s[2][7:0], s[1][7:0], s[0][7:0]} ^ {23'h0, bad};
		@(posedge i_clk);
		o_line_end <= 1'b0;
		o_chksum   <= ~o_chksum;
	endtask : send_line
endmodule : cpdr_remote_tx
`default_nettype wire
